//--- dv/cim_host_model.sv
// host model: i2c master on the register bus, sda with pull-up
`timescale 1ns/1ps
module cim_host_model
(
  input  wire logic core_clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic sda_drv;
  // ---------------------------------------------------------------
  // wire level: pull-up unless a side pulls low
  // ---------------------------------------------------------------
  assign sda = sda_drv & ~sda_oe;
  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // scl low for 9 clocks, above the 8 the target needs
  task automatic xbit(input logic b, output logic r);
    sda_drv = b;
    hc(8);
    scl = 1'b1;
    hc(4);
    r = sda;
    hc(4);
    scl = 1'b0;
    hc(1);
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
      xbit(d[i], r[i]);
  endtask
  task automatic start;
    sda_drv = 1'b1;
    hc(4);
    scl = 1'b1;
    hc(8);
    sda_drv = 1'b0;
    hc(8);
    scl = 1'b0;
    hc(8);
  endtask
  task automatic stop;
    sda_drv = 1'b0;
    hc(8);
    scl = 1'b1;
    hc(8);
    sda_drv = 1'b1;
    hc(8);
  endtask
  // pointer write, then one data byte or repeated start and one read
  task automatic access(input logic [6:0] dev, input logic [7:0] a, input logic wr,
                        input logic [7:0] d, output logic [7:0] q, output logic ok);
    logic [8:0] r0, r1, r2, r3;
    start;
    xfer({dev, 2'b01}, r0);
    xfer({a, 1'b1}, r1);
    r3 = 9'h1ff;
    if (wr)
      xfer({d, 1'b1}, r2);
    else
    begin
      start;
      xfer({dev, 2'b11}, r2);
      xfer(9'h1ff, r3);
    end
    stop;
    q  = r3[8:1];
    ok = ~r0[0] & ~r1[0] & ~r2[0];
  endtask
endmodule

//--- dv/cim_top_tb.sv
// testbench: registers, interrupt, detection, input limit, charge phases
`timescale 1ns/1ps
module cim_top_tb;
  import cim_pkg::*;
  logic       core_clk   = 1'b0;
  logic       nrst       = 1'b0;
  logic       scl, sda, sda_out, sda_oe, irq_n, ok;
  logic [7:0] q;
  cim_sense_s sense      = '0;
  cim_drive_s drive_q;
  int         error_cnt  = 0;
  int         num_checks = 0;
  always #50 core_clk = ~core_clk;
  cim_host_model i_cim_host_model (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  // id codes below are arbitrary
  cim_top #(.MAKER_CODE(4'ha), .SILICON_REVISION(4'h6)) i_cim_top (.core_clk(core_clk), .nrst(nrst),
    .scl_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .sense(sense),
    .drive_q(drive_q), .irq_n(irq_n));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_cim_host_model.access(I2C_DEV_ADDR, a, 1'b1, d, q, ok);
    chk({7'h0, ok}, 8'h01);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_cim_host_model.access(I2C_DEV_ADDR, a, 1'b0, 8'h00, q, ok);
    chk({7'h0, ok}, 8'h01);
    chk(q, e);
  endtask
  // detection lasts 1000 clocks; bound leaves margin
  task automatic wait_det;
    int n;
    for (n = 0; n < 2000 && drive_q.detecting !== 1'b0; n++)
      cyc(1);
    if (n == 2000)
    begin
      error_cnt++;
      complete_run;
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rd(OFS_CHG_MASK, MASK_RST);
    chk({7'h0, sda_out}, 8'h00);
    rd(OFS_BST_MASK, MASK_RST);
    rd(OFS_PART_ID, 8'ha6);
    rd(OFS_VFLOOR, {5'h0, VFLOOR_RST});
    chk({6'h0, drive_q.ilim}, {6'h0, LIM_500});
    wr(OFS_CHG_MASK, 8'ha5);
    rd(OFS_CHG_MASK, 8'ha5);
    wr(OFS_BST_MASK, 8'hff);
    rd(OFS_BST_MASK, 8'hf8);
    wr(OFS_PART_ID, 8'h00);
    rd(OFS_PART_ID, 8'ha6);
    rd(8'h3f, 8'h00);
    i_cim_host_model.access(7'h21, OFS_CHG_MASK, 1'b1, 8'h00, q, ok);
    chk({7'h0, ok}, 8'h00);
    rd(OFS_CHG_MASK, 8'ha5);
  endtask
  task automatic t_irq;
    wr(OFS_CHG_MASK, 8'hff);
    sense.chg_ev[VFLOOR_EV] = 1'b1;
    sense.bst_ev[0] = 1'b1;
    cyc(6);
    chk({7'h0, irq_n}, 8'h01);
    sense = '0;
    cyc(4);
    rd(OFS_CHG_FLAG, 8'h01);
    wr(OFS_CHG_MASK, 8'h00);
    chk({7'h0, irq_n}, 8'h01);
    sense.chg_ev[VFLOOR_EV] = 1'b1;
    cyc(5);
    chk({7'h0, irq_n}, 8'h00);
    sense = '0;
    cyc(4);
    rd(OFS_BST_FLAG, 8'h08);
    chk({7'h0, irq_n}, 8'h00);
    rd(OFS_CHG_FLAG, 8'h01);
    cyc(3);
    chk({7'h0, irq_n}, 8'h01);
    wr(OFS_VFLOOR, 8'h07);
    chk({5'h0, drive_q.vfloor}, 8'h07);
  endtask
  task automatic t_det;
    sense.dp_dm_short = 1'b1;
    wr(OFS_CTRL, 8'h80);
    chk({7'h0, drive_q.detecting}, 8'h01);
    rd(OFS_CTRL, 8'h00);
    wait_det;
    rd(OFS_DET_STAT, 8'h03);
    for (int c = 0; c < 4; c++)
    begin
      wr(OFS_LIMIT, 8'(c));
      chk({6'h0, drive_q.ilim}, (c < 2) ? 8'h02 : 8'(c));
    end
    wr(OFS_CHG_CFG, 8'h20);
    for (int c = 0; c < 4; c++)
    begin
      wr(OFS_LIMIT, 8'(c));
      chk({6'h0, drive_q.ilim}, 8'(c));
    end
    sense.detect_disable_pin = 1'b1;
    cyc(4);
    wr(OFS_CTRL, 8'h80);
    chk({7'h0, drive_q.detecting}, 8'h00);
    sense = '0;
    cyc(4);
    sense.vin_good = 1'b1;
    cyc(5);
    chk({7'h0, drive_q.detecting}, 8'h01);
    wait_det;
    rd(OFS_DET_STAT, 8'h02);
    wr(OFS_CHG_CFG, 8'h00);
    wr(OFS_LIMIT, 8'h00);
    chk({6'h0, drive_q.ilim}, {6'h0, LIM_500});
  endtask
  task automatic t_chg;
    wr(OFS_CHG_CFG, 8'hc5);
    cyc(4);
    chk({6'h0, drive_q.phase}, {6'h0, PH_PRE});
    chk({6'h0, drive_q.imode}, {6'h0, IM_PRECHARGE});
    chk({3'h0, drive_q.loops_en}, 8'h1f);
    sense.batt_above_prec = 1'b1;
    cyc(6);
    chk({6'h0, drive_q.phase}, {6'h0, PH_FAST});
    chk({2'h0, drive_q.imode, drive_q.ichg}, {2'h0, IM_FIELD, 4'h5});
    wr(OFS_CHG_CFG, 8'hd5);
    chk({6'h0, drive_q.imode}, {6'h0, IM_REDUCED});
    sense.batt_near_vreg = 1'b1;
    cyc(6);
    chk({6'h0, drive_q.phase}, {6'h0, PH_CV});
    sense.ind_over_limit = 1'b1;
    cyc(4);
    chk({7'h0, drive_q.charge_on}, 8'h00);
    sense.ind_over_limit = 1'b0;
    cyc(6);
    chk({7'h0, drive_q.charge_on}, 8'h01);
    wr(OFS_CHG_MASK, 8'hff);
    sense.chg_ev[7] = 1'b1;
    cyc(6);
    chk({7'h0, drive_q.charge_on}, 8'h00);
    chk({7'h0, irq_n}, 8'h01);
    rd(OFS_CHG_CFG, 8'h15);
  endtask
  initial
  begin
    cyc(20);
    nrst = 1'b1;
    cyc(4);
    t_regs;
    t_irq;
    t_det;
    t_chg;
    complete_run;
  end
endmodule

//--- hdl/cim_i2c_target.sv
// module: i2c target turning bus frames into register strobes
`timescale 1ns/1ps
module cim_i2c_target
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic [7:0]  rd_data,
  output cim_pkg::cim_bus_s bus_q,
  output logic             sda_oe
);
  import cim_pkg::*;
  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_REG, ST_WR, ST_RD} cim_i2c_e;
  cim_i2c_e   st_q;
  logic       scl_q;
  logic       sda_q;
  logic       load_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] ptr_q;
  wire scl_rise  = scl & ~scl_q;
  wire scl_fall  = ~scl & scl_q;
  wire start     = scl & scl_q & sda_q & ~sda;
  wire stop      = scl & scl_q & ~sda_q & sda;
  wire dev_match = sh_q[7:1] == I2C_DEV_ADDR;
  wire busy      = st_q != ST_IDLE;
  wire rd_next   = st_q == ST_RD || (st_q == ST_DEV && sh_q[0]);
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      st_q <= ST_IDLE; scl_q <= 1'b1; sda_q <= 1'b1; load_q <= 1'b0;
      cnt_q <= 4'h0; sh_q <= 8'h00; ptr_q <= 8'h00; sda_oe <= 1'b0;
      bus_q <= '0;
    end
    else
    begin
      scl_q <= scl; sda_q <= sda; load_q <= 1'b0;
      bus_q.wr <= 1'b0; bus_q.rd <= 1'b0;
      if (start)
      begin
        st_q <= ST_DEV; cnt_q <= 4'h0; sda_oe <= 1'b0;
      end
      else if (stop)
      begin
        st_q <= ST_IDLE; sda_oe <= 1'b0;
      end
      // data is loaded in the strobe cycle so a clear-on-read loses nothing
      else if (load_q)
      begin
        sh_q <= rd_data; sda_oe <= ~rd_data[7];
      end
      else if (busy && scl_rise)
      begin
        if (cnt_q < 4'h8)
        begin
          cnt_q <= cnt_q + 4'h1;
          if (st_q != ST_RD) sh_q <= {sh_q[6:0], sda};
        end
        else if (st_q == ST_RD && sda) st_q <= ST_IDLE;
      end
      else if (busy && scl_fall)
      begin
        if (cnt_q == 4'h8)
        begin
          cnt_q <= 4'h9;
          sda_oe <= st_q != ST_RD && (st_q != ST_DEV || dev_match);
          if (st_q == ST_DEV && !dev_match) st_q <= ST_IDLE;
          if (st_q == ST_REG) ptr_q <= sh_q;
          if (st_q == ST_WR)
          begin
            bus_q.wr <= 1'b1; bus_q.addr <= ptr_q; bus_q.data <= sh_q; ptr_q <= ptr_q + 8'h01;
          end
        end
        else if (cnt_q == 4'h9)
        begin
          cnt_q <= 4'h0; sda_oe <= 1'b0;
          if (st_q == ST_DEV) st_q <= sh_q[0] ? ST_RD : ST_REG;
          else if (st_q == ST_REG) st_q <= ST_WR;
          if (rd_next)
          begin
            bus_q.rd <= 1'b1; bus_q.addr <= ptr_q; ptr_q <= ptr_q + 8'h01; load_q <= 1'b1;
          end
        end
        else if (st_q == ST_RD && cnt_q != 4'h0)
        begin
          sh_q <= {sh_q[6:0], 1'b0}; sda_oe <= ~sh_q[6];
        end
      end
    end
  end
endmodule

//--- hdl/cim_pkg.sv
// package: constants and carriers for the charger control block
package cim_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CHG_CFG   = 8'h01;
  localparam logic [7:0] OFS_LIMIT     = 8'h02;
  localparam logic [7:0] OFS_VFLOOR    = 8'h03;
  localparam logic [7:0] OFS_DET_STAT  = 8'h07;
  localparam logic [7:0] OFS_CHG_FLAG  = 8'h09;
  localparam logic [7:0] OFS_BST_FLAG  = 8'h0a;
  localparam logic [7:0] OFS_CHG_MASK  = 8'h0c;
  localparam logic [7:0] OFS_BST_MASK  = 8'h0d;
  localparam logic [7:0] OFS_PART_ID   = 8'h0e;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TRIG_BIT   = 7;
  localparam int CHEN_LSB   = 6;
  localparam int LIMIT_SOURCE_SELECT_BIT = 5;
  localparam int LOWCHG_BIT = 4;
  localparam int DONE_BIT   = 1;
  localparam int RES_BIT    = 0;
  localparam int BST_LSB    = 3;
  localparam int VFLOOR_EV  = 0;
  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [1:0] CHEN_RST   = 2'h3;
  localparam logic [1:0] CHEN_OFF   = 2'h0;
  localparam logic [1:0] LIMIT_RST  = 2'h1;
  localparam logic [2:0] VFLOOR_RST = 3'h2;
  localparam logic [3:0] ICHG_RST   = 4'h0;
  localparam logic [1:0] LIM_100    = 2'h0;
  localparam logic [1:0] LIM_500    = 2'h1;
  localparam logic [1:0] LIM_975    = 2'h2;
  localparam logic [1:0] LIM_NONE   = 2'h3;
  localparam logic [7:0] CHG_FAULTS = 8'he4;
  localparam logic [6:0] I2C_DEV_ADDR = 7'h35;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int DET_TIME_NS   = 100000;
  localparam int DET_CYC_I     = (DET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] DET_LAST = 10'(DET_CYC_I - 1);
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PH_OFF, PH_PRE, PH_FAST, PH_CV} cim_phase_e;
  typedef enum logic [1:0] {IM_PRECHARGE, IM_REDUCED, IM_FIELD} cim_imode_e;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } cim_bus_s;
  typedef struct packed {
    logic       vin_good;
    logic       dp_dm_short;
    logic       detect_disable_pin;
    logic       batt_above_prec;
    logic       batt_near_vreg;
    logic       ind_over_limit;
    logic [7:0] chg_ev;
    logic [4:0] bst_ev;
  } cim_sense_s;
  typedef struct packed {
    logic       charge_on;
    cim_phase_e phase;
    logic [4:0] loops_en;
    cim_imode_e imode;
    logic [3:0] ichg;
    logic [1:0] ilim;
    logic [2:0] vfloor;
    logic       detecting;
  } cim_drive_s;
endpackage

//--- hdl/cim_port_detect.sv
// module: timed charger-port detection with inhibit
`timescale 1ns/1ps
module cim_port_detect
(
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic start,
  input  wire logic inhibit,
  input  wire logic dp_dm_short,
  output logic      busy_q,
  output logic      done_q,
  output logic      result_q
);
  import cim_pkg::*;
  logic [9:0] cnt_q;
  wire finish = busy_q && cnt_q == DET_LAST;
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      busy_q <= 1'b0; done_q <= 1'b0; result_q <= 1'b0; cnt_q <= 10'h000;
    end
    else if (inhibit)
    begin
      busy_q <= 1'b0; cnt_q <= 10'h000;
    end
    else if (start)
    begin
      busy_q <= 1'b1; done_q <= 1'b0; cnt_q <= 10'h000;
    end
    else if (finish)
    begin
      busy_q <= 1'b0; done_q <= 1'b1; result_q <= dp_dm_short;
    end
    else if (busy_q) cnt_q <= cnt_q + 10'h001;
  end
endmodule

//--- hdl/cim_top.sv
// top: charger registers, event flags, detection, input limit and charge phases
`timescale 1ns/1ps
module cim_top
#(
  parameter logic [3:0] MAKER_CODE       = 4'h5, // arbitrary value
  parameter logic [3:0] SILICON_REVISION = 4'h3  // arbitrary value
)
(
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         scl_pin,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  input  cim_pkg::cim_sense_s sense,
  output cim_pkg::cim_drive_s drive_q,
  output logic              irq_n
);
  import cim_pkg::*;
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  cim_sense_s sense_s1_q;
  cim_sense_s sns;
  logic       scl_s1_q;
  logic       scl_s2_q;
  logic       sda_s1_q;
  logic       sda_s2_q;
  logic       vin_good_q3;
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sense_s1_q <= '0; sns <= '0; vin_good_q3 <= 1'b0;
      scl_s1_q <= 1'b1; scl_s2_q <= 1'b1; sda_s1_q <= 1'b1; sda_s2_q <= 1'b1;
    end
    else
    begin
      sense_s1_q <= sense; sns <= sense_s1_q; vin_good_q3 <= sns.vin_good;
      scl_s1_q <= scl_pin; scl_s2_q <= scl_s1_q;
      sda_s1_q <= sda_in; sda_s2_q <= sda_s1_q;
    end
  end
  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  cim_bus_s   bus;
  logic [7:0] rd_data;
  cim_i2c_target u_i2c
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .scl      (scl_s2_q),
    .sda      (sda_s2_q),
    .rd_data  (rd_data),
    .bus_q    (bus),
    .sda_oe   (sda_oe)
  );
  function automatic logic hit(input cim_bus_s b, input logic strobe, input logic [7:0] ofs);
    return strobe && b.addr == ofs;
  endfunction
  wire wr_ctrl  = hit(bus, bus.wr, OFS_CTRL);
  wire wr_cfg   = hit(bus, bus.wr, OFS_CHG_CFG);
  wire wr_limit = hit(bus, bus.wr, OFS_LIMIT);
  wire wr_vfl   = hit(bus, bus.wr, OFS_VFLOOR);
  wire wr_cmask = hit(bus, bus.wr, OFS_CHG_MASK);
  wire wr_bmask = hit(bus, bus.wr, OFS_BST_MASK);
  wire rd_cflag = hit(bus, bus.rd, OFS_CHG_FLAG);
  wire rd_bflag = hit(bus, bus.rd, OFS_BST_FLAG);
  wire rd_id    = hit(bus, bus.rd, OFS_PART_ID);
  // ---------------------------------------------------------------
  // control and mask registers
  // ---------------------------------------------------------------
  logic       trig_q;
  logic [1:0] chen_q;
  logic       limit_source_select_q;
  logic       lowchg_q;
  logic [3:0] ichg_q;
  logic [1:0] ilim_field_q;
  logic [2:0] vfloor_q;
  logic [7:0] chg_mask_q;
  logic [7:0] bst_mask_q;
  wire        chg_fault = |(sns.chg_ev & CHG_FAULTS);
  // fault wins over a host write so a stuck fault cannot be overridden
  wire [1:0]  chen_d = chg_fault ? CHEN_OFF : (wr_cfg ? bus.data[CHEN_LSB+:2] : chen_q);
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      trig_q <= 1'b0; chen_q <= CHEN_RST; limit_source_select_q <= 1'b0; lowchg_q <= 1'b0;
      ichg_q <= ICHG_RST; ilim_field_q <= LIMIT_RST; vfloor_q <= VFLOOR_RST;
      chg_mask_q <= MASK_RST; bst_mask_q <= MASK_RST;
    end
    else
    begin
      trig_q <= wr_ctrl && bus.data[TRIG_BIT] && !trig_q;
      chen_q <= chen_d;
      if (wr_cfg)
      begin
        limit_source_select_q <= bus.data[LIMIT_SOURCE_SELECT_BIT]; lowchg_q <= bus.data[LOWCHG_BIT]; ichg_q <= bus.data[3:0];
      end
      if (wr_limit) ilim_field_q <= bus.data[1:0];
      if (wr_vfl) vfloor_q <= bus.data[2:0];
      if (wr_cmask) chg_mask_q <= bus.data;
      if (wr_bmask) bst_mask_q <= {bus.data[7:BST_LSB], 3'h0};
    end
  end
  // ---------------------------------------------------------------
  // port detection
  // ---------------------------------------------------------------
  logic det_busy;
  logic det_done;
  logic det_result;
  wire  vin_rise  = sns.vin_good & ~vin_good_q3;
  wire  det_start = trig_q | vin_rise;
  cim_port_detect u_det
  (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .start       (det_start),
    .inhibit     (sns.detect_disable_pin),
    .dp_dm_short (sns.dp_dm_short),
    .busy_q      (det_busy),
    .done_q      (det_done),
    .result_q    (det_result)
  );
  // ---------------------------------------------------------------
  // event flags and interrupt
  // ---------------------------------------------------------------
  logic [7:0] chg_flag_q;
  logic [4:0] bst_flag_q;
  // clear applies to the old value only, so an event in the same cycle survives
  wire  [7:0] chg_flag_d = (rd_cflag ? 8'h00 : chg_flag_q) | sns.chg_ev;
  wire  [4:0] bst_flag_d = (rd_bflag ? 5'h00 : bst_flag_q) | sns.bst_ev;
  wire        irq_any = |(chg_flag_q & ~chg_mask_q) | |(bst_flag_q & ~bst_mask_q[7:BST_LSB]);
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      chg_flag_q <= 8'h00; bst_flag_q <= 5'h00; irq_n <= 1'b1;
    end
    else
    begin
      chg_flag_q <= chg_flag_d; bst_flag_q <= bst_flag_d;
      irq_n <= ~irq_any;
    end
  end
  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire [7:0] id_word  = {MAKER_CODE, SILICON_REVISION};
  wire [7:0] cfg_word = {chen_q, limit_source_select_q, lowchg_q, ichg_q};
  wire [7:0] det_word = {6'h00, det_done, det_result};
  assign rd_data = bus.addr == OFS_CTRL     ? {trig_q, 7'h00} :
                   bus.addr == OFS_CHG_CFG  ? cfg_word :
                   bus.addr == OFS_LIMIT    ? {6'h00, ilim_field_q} :
                   bus.addr == OFS_VFLOOR   ? {5'h00, vfloor_q} :
                   bus.addr == OFS_DET_STAT ? det_word :
                   bus.addr == OFS_CHG_FLAG ? chg_flag_q :
                   bus.addr == OFS_BST_FLAG ? {bst_flag_q, 3'h0} :
                   bus.addr == OFS_CHG_MASK ? chg_mask_q :
                   bus.addr == OFS_BST_MASK ? bst_mask_q :
                   bus.addr == OFS_PART_ID  ? id_word : 8'h00;
  // ---------------------------------------------------------------
  // input current limit
  // ---------------------------------------------------------------
  wire [1:0] det_code = det_result ? LIM_975 : LIM_500;
  wire [1:0] lim_max  = ilim_field_q > det_code ? ilim_field_q : det_code;
  wire [1:0] ilim_d   = limit_source_select_q ? ilim_field_q : lim_max;
  // ---------------------------------------------------------------
  // charge phase sequencing
  // ---------------------------------------------------------------
  cim_phase_e phase_d;
  // inductor limit bypasses every register setting
  wire charge_go = chen_q[1] && sns.vin_good && !sns.ind_over_limit && !chg_fault;
  always_comb
  begin
    phase_d = drive_q.phase;
    if (!charge_go) phase_d = PH_OFF;
    else
      unique case (drive_q.phase)
        PH_OFF:  phase_d = PH_PRE;
        PH_PRE:  if (sns.batt_above_prec) phase_d = PH_FAST;
        PH_FAST: if (!sns.batt_above_prec) phase_d = PH_PRE;
                 else if (sns.batt_near_vreg) phase_d = PH_CV;
        PH_CV:   if (!sns.batt_above_prec) phase_d = PH_PRE;
      endcase
  end
  wire        on_d    = phase_d != PH_OFF;
  wire        pre_d   = phase_d == PH_PRE;
  // reduced current applies in every phase except precharge, constant voltage included
  wire cim_imode_e imode_d = pre_d ? IM_PRECHARGE : (lowchg_q ? IM_REDUCED : IM_FIELD);
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      drive_q <= '0; drive_q.imode <= IM_PRECHARGE; drive_q.ilim <= LIMIT_RST;
      drive_q.vfloor <= VFLOOR_RST; sda_out <= 1'b0;
    end
    else
    begin
      drive_q.charge_on <= on_d;
      drive_q.phase     <= phase_d;
      drive_q.loops_en  <= {5{on_d}};
      drive_q.imode     <= imode_d;
      drive_q.ichg      <= ichg_q;
      drive_q.ilim      <= ilim_d;
      drive_q.vfloor    <= vfloor_q;
      drive_q.detecting <= det_busy;
      sda_out           <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  sequence cycle_start;
    drive_q.phase == PH_OFF ##1 drive_q.phase != PH_OFF;
  endsequence
  chg_mask_wr_a: assert property (wr_cmask |=> chg_mask_q == $past(bus.data))
    else $error("charger mask did not take write");
  bst_mask_wr_a: assert property (wr_bmask |=> bst_mask_q == {$past(bus.data[7:3]), 3'h0})
    else $error("boost mask bits wrong");
  masked_fault_a: assert property ((chg_fault && &chg_mask_q) |-> ##2 !drive_q.charge_on)
    else $error("masked fault did not stop charging");
  id_read_a: assert property (rd_id |-> rd_data == {MAKER_CODE, SILICON_REVISION})
    else $error("id register read wrong");
  vfloor_irq_a: assert property ((sns.chg_ev[VFLOOR_EV] && !chg_mask_q[VFLOOR_EV] && !wr_cmask)
    |-> ##2 !irq_n)
    else $error("floor loop did not raise interrupt");
  trig_clear_a: assert property (trig_q |=> !trig_q)
    else $error("trigger bit not self cleared");
  det_inhibit_a: assert property (sns.detect_disable_pin |=> !det_busy)
    else $error("detection ran while disabled");
  limit_max_a: assert property (!limit_source_select_q |=> drive_q.ilim >= $past(ilim_field_q))
    else $error("limit below programmed field");
  limit_sel_a: assert property (limit_source_select_q |=> drive_q.ilim == $past(ilim_field_q))
    else $error("select did not use field only");
  phase_start_a: assert property (cycle_start |-> drive_q.phase == PH_PRE)
    else $error("charge cycle did not start in precharge");
  ind_stop_a: assert property (sns.ind_over_limit |=> !drive_q.charge_on)
    else $error("inductor limit did not stop charging");
  fault_off_a: assert property (chg_fault |=> chen_q == CHEN_OFF)
    else $error("fault did not clear charge enable");
  irq_release_a: assert property (!irq_any |=> irq_n)
    else $error("interrupt held with no unmasked flag");
  // ---------------------------------------------------------------
  // further checks
  // ---------------------------------------------------------------
  sequence pre_to_fast;
    drive_q.phase == PH_PRE && charge_go && sns.batt_above_prec;
  endsequence
  sequence fast_to_cv;
    drive_q.phase == PH_FAST && charge_go && sns.batt_above_prec && sns.batt_near_vreg;
  endsequence
  phase_fast_a: assert property (pre_to_fast |=> drive_q.phase == PH_FAST)
    else $error("precharge did not move to fast charge");
  phase_cv_a: assert property (fast_to_cv |=> drive_q.phase == PH_CV)
    else $error("fast charge did not move to constant voltage");
  chg_mask_hold_a: assert property (!wr_cmask |=> $stable(chg_mask_q))
    else $error("charger mask changed without write");
  bst_low_zero_a: assert property (bst_mask_q[2:0] == 3'h0)
    else $error("unused boost mask bits set");
  vfloor_flag_a: assert property (sns.chg_ev[VFLOOR_EV] |=> chg_flag_q[VFLOOR_EV])
    else $error("floor loop warning flag not set");
  vfloor_drive_a: assert property (wr_vfl |=> ##1 drive_q.vfloor == $past(bus.data[2:0], 2))
    else $error("floor field not driven");
  trig_set_a: assert property ((wr_ctrl && bus.data[TRIG_BIT] && !trig_q) |=> trig_q)
    else $error("trigger write not taken");
  det_power_a: assert property ((vin_rise && !sns.detect_disable_pin) |=> det_busy)
    else $error("power-up did not start detection");
  det_result_a: assert property ($rose(det_done) |-> det_result == $past(sns.dp_dm_short))
    else $error("detection result does not match lines");
  det_code_a: assert property ((!limit_source_select_q && ilim_field_q <= det_code) |=> drive_q.ilim == $past(det_code))
    else $error("limit did not follow detection result");
  pre_current_a: assert property ((charge_go && !sns.batt_above_prec) |=> drive_q.imode == IM_PRECHARGE)
    else $error("current above precharge while battery low");
  loops_on_a: assert property (drive_q.charge_on |-> drive_q.loops_en == 5'h1f)
    else $error("regulation loop off while charging");
  reduced_cur_a: assert property ((phase_d == PH_FAST && lowchg_q) |=> drive_q.imode == IM_REDUCED)
    else $error("reduced current not applied");
  field_cur_a: assert property ((phase_d == PH_FAST && !lowchg_q) |=> drive_q.imode == IM_FIELD)
    else $error("charge current field not applied");
  fault_stop_a: assert property (chg_fault |=> !drive_q.charge_on)
    else $error("fault did not stop charging");
  irq_assert_a: assert property (irq_any |=> !irq_n)
    else $error("interrupt not raised for unmasked flag");
endmodule
